// ===== logic/ser_params.svh
// Register indices, field positions, reset values and codes of the status and error bank.
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SER_IDX_PART_IDENTITY   6'h00
`define SER_IDX_FAULT_REPORT    6'h02
`define SER_IDX_SENSOR_COND     6'h03
`define SER_IDX_IRQ_STATUS      6'h04
`define SER_IDX_IRQ_MASK        6'h05

// ****************************************************************
// Field positions of fault_report
// ****************************************************************
`define SER_FAULT_BOOT_BIT      0
`define SER_FAULT_CODE_LSB      1
`define SER_FAULT_CODE_MSB      4
`define SER_FAULT_QUEUE_BIT     6
`define SER_FAULT_AUXM_BIT      7

// ****************************************************************
// Field positions of sensor_condition
// ****************************************************************
`define SER_COND_MANUAL_BIT     2
`define SER_COND_CMD_IDLE_BIT   4
`define SER_COND_AUX_FRESH_BIT  5
`define SER_COND_ACC_FRESH_BIT  7

// ****************************************************************
// Persistent fault codes and reset values
// ****************************************************************
`define SER_CODE_NONE           4'h0
`define SER_CODE_ACCELEROMETER_CONFIGURATION       4'h1
`define SER_RST_FAULT_REPORT    8'h00
`define SER_RST_SENSOR_COND     8'h10
`define SER_RST_CMD_IDLE        1'b1

// ****************************************************************
// Interrupt event bits and bus answers
// ****************************************************************
`define SER_IRQ_WIDTH           5
`define SER_IRQ_BOOT_BIT        0
`define SER_IRQ_QUEUE_BIT       1
`define SER_IRQ_AUXM_BIT        2
`define SER_IRQ_ACC_BIT         3
`define SER_IRQ_AUX_BIT         4
`define SER_RESP_OKAY           2'b00
`define SER_RESP_SLVERR         2'b10

`endif

// ===== logic/ser_pkg.sv
// Types shared by the status and error register bank.
package ser_pkg;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        SER_SEL_NONE      = 3'b000,
        SER_SEL_IDENTITY  = 3'b001,
        SER_SEL_FAULT     = 3'b010,
        SER_SEL_COND      = 3'b011,
        SER_SEL_IRQ_STAT  = 3'b100,
        SER_SEL_IRQ_MASK  = 3'b101
    } ser_sel_e;

    // Read channel state.
    typedef enum logic {
        SER_RD_IDLE = 1'b0,
        SER_RD_RESP = 1'b1
    } ser_rd_e;

    // One register byte.
    typedef logic [7:0] ser_byte_t;

endpackage

// ===== logic/ser_regbank.sv
// Identification, fault and condition registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "ser_params.svh"
module ser_regbank import ser_pkg::*; #(
    parameter ser_byte_t PART_IDENTITY_CODE = 8'h5a // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Events and levels from the sensor core, same clock.
    input  wire logic        queueDropped,
    input  wire logic        auxMasterFault,
    input  wire logic        accelNewSample,
    input  wire logic        auxNewSample,
    input  wire logic        accelDataRead,
    input  wire logic        auxDataRead,
    input  wire logic        commandBusy,
    input  wire logic        manualAuxiliaryTransfer,
    input  wire logic        accelerometerConfigurationBad,
    // Boot or power fault level from the supervisor, asynchronous.
    input  wire logic        bootFault,
    // Interrupt.
    output logic             irq
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Only word-aligned addresses hit; anything else answers SLVERR.
    function automatic ser_sel_e decodeSel(input logic [7:0] addr);
        ser_sel_e sel;
        sel = SER_SEL_NONE;
        if (addr[1:0] != 2'b00) begin
            sel = SER_SEL_NONE;
        end else if (addr[7:2] == `SER_IDX_PART_IDENTITY) begin
            sel = SER_SEL_IDENTITY;
        end else if (addr[7:2] == `SER_IDX_FAULT_REPORT) begin
            sel = SER_SEL_FAULT;
        end else if (addr[7:2] == `SER_IDX_SENSOR_COND) begin
            sel = SER_SEL_COND;
        end else if (addr[7:2] == `SER_IDX_IRQ_STATUS) begin
            sel = SER_SEL_IRQ_STAT;
        end else if (addr[7:2] == `SER_IDX_IRQ_MASK) begin
            sel = SER_SEL_IRQ_MASK;
        end
        return sel;
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic       bootSync;       // Synchronised boot fault level.
    logic       bootSyncDly;    // Delayed copy for edge detection.
    logic [2:0] faultFlags;     // Sticky boot, queue and aux-master faults.
    logic [2:0] faultClr;       // Clear pulses for the fault flags.
    logic [1:0] freshFlags;     // Sticky accel and aux fresh flags.
    logic [3:0] faultCode;      // Persistent fault code.
    logic       cmdIdle;        // Registered command idle level.
    logic       manualBusy;     // Registered manual transfer level.
    logic [`SER_IRQ_WIDTH-1:0] irqEvents;  // Interrupt source pulses.
    logic [`SER_IRQ_WIDTH-1:0] irqClr;     // Write-one-to-clear pulses.
    logic [`SER_IRQ_WIDTH-1:0] irqStatus;  // Sticky interrupt status.
    logic [`SER_IRQ_WIDTH-1:0] irqMask;    // Interrupt enable mask.
    logic [`SER_IRQ_WIDTH-1:0] next_irqMask;
    logic       next_bootSyncDly, next_cmdIdle, next_manualBusy, next_irq;
    logic [3:0] next_faultCode;
    // Write channel state.
    logic       awHeld, wHeld, next_awHeld, next_wHeld;
    logic [7:0] awAddrQ, next_awAddrQ;
    logic [31:0] wDataQ, next_wDataQ;
    logic [3:0] wStrbQ, next_wStrbQ;
    logic       next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    ser_sel_e   wrSel;          // Register hit by the held write address.
    logic       doWrite;        // Both halves held and no response pending.
    // Read channel state.
    ser_rd_e    rdState, next_rdState;
    ser_sel_e   rdSel;          // Register hit by the offered read address.
    logic       arTake;         // Read address handshake this cycle.
    logic       faultRead;      // Read of fault_report taken this cycle.
    logic       next_arready, next_rvalid;
    logic [31:0] next_rdata, rdWord;
    logic [1:0] next_rresp;

    // ****************************************************************
    // Flag sources
    // ****************************************************************
    // The supervisor level comes from another domain, so it is synchronised first.
    ser_sync2 #(.WIDTH(1)) u_bootSync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (bootFault),
        .syncOut (bootSync)
    );

    // Reading fault_report clears the two read-clear flags; boot fault never.
    always_comb begin
        faultClr = {faultRead, faultRead, 1'b0};
    end

    // Fault flags: [0] boot, [1] queue overflow, [2] auxiliary master.
    ser_sticky #(.WIDTH(3)) u_faults (
        .sys_clk (sys_clk),
        .rst     (rst),
        .setBits ({auxMasterFault, queueDropped, bootSync}),
        .clrBits (faultClr),
        .flags   (faultFlags)
    );

    // Fresh flags: [1] accelerometer, [0] auxiliary; a data read clears them.
    ser_sticky #(.WIDTH(2)) u_fresh (
        .sys_clk (sys_clk),
        .rst     (rst),
        .setBits ({accelNewSample, auxNewSample}),
        .clrBits ({accelDataRead, auxDataRead}),
        .flags   (freshFlags)
    );

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    // Boot fault raises an event on each rising edge of its synchronised level only.
    always_comb begin
        irqEvents = '0;
        irqEvents[`SER_IRQ_BOOT_BIT]  = bootSync & ~bootSyncDly;
        irqEvents[`SER_IRQ_QUEUE_BIT] = queueDropped;
        irqEvents[`SER_IRQ_AUXM_BIT]  = auxMasterFault;
        irqEvents[`SER_IRQ_ACC_BIT]   = accelNewSample;
        irqEvents[`SER_IRQ_AUX_BIT]   = auxNewSample;
        irqClr = '0;
        if (doWrite && wrSel == SER_SEL_IRQ_STAT && wStrbQ[0]) begin
            irqClr = wDataQ[`SER_IRQ_WIDTH-1:0];
        end
    end

    ser_sticky #(.WIDTH(`SER_IRQ_WIDTH)) u_irqStatus (
        .sys_clk (sys_clk),
        .rst     (rst),
        .setBits (irqEvents),
        .clrBits (irqClr),
        .flags   (irqStatus)
    );

    // ****************************************************************
    // Condition and code registers
    // ****************************************************************
    // Levels are registered so every read sees one stable sample.
    always_comb begin
        next_bootSyncDly = bootSync;
        next_cmdIdle     = ~commandBusy;
        next_manualBusy  = manualAuxiliaryTransfer;
        next_faultCode   = accelerometerConfigurationBad ?
                           `SER_CODE_ACCELEROMETER_CONFIGURATION : `SER_CODE_NONE;
        next_irqMask     = irqMask;
        if (doWrite && wrSel == SER_SEL_IRQ_MASK && wStrbQ[0]) begin
            next_irqMask = wDataQ[`SER_IRQ_WIDTH-1:0];
        end
        next_irq = |(irqStatus & irqMask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bootSyncDly <= 1'b0;
            cmdIdle     <= `SER_RST_CMD_IDLE;
            manualBusy  <= 1'b0;
            faultCode   <= `SER_CODE_NONE;
            irqMask     <= '0;
            irq         <= 1'b0;
        end else begin
            bootSyncDly <= next_bootSyncDly;
            cmdIdle     <= next_cmdIdle;
            manualBusy  <= next_manualBusy;
            faultCode   <= next_faultCode;
            irqMask     <= next_irqMask;
            irq         <= next_irq;
        end
    end

    // ****************************************************************
    // Write channel
    // ****************************************************************
    // Address and data are taken in either order; writes to read-only
    // registers are answered OKAY and change nothing.
    always_comb begin
        wrSel        = decodeSel(awAddrQ);
        doWrite      = awHeld & wHeld & ~s_axi_bvalid;
        next_awHeld  = awHeld | (s_axi_awvalid & s_axi_awready);
        next_wHeld   = wHeld | (s_axi_wvalid & s_axi_wready);
        next_awAddrQ = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awAddrQ;
        next_wDataQ  = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wDataQ;
        next_wStrbQ  = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wStrbQ;
        next_bvalid  = s_axi_bvalid & ~s_axi_bready;
        next_bresp   = s_axi_bresp;
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = (wrSel == SER_SEL_NONE) ? `SER_RESP_SLVERR
                                                  : `SER_RESP_OKAY;
        end
        next_awready = ~next_awHeld;
        next_wready  = ~next_wHeld;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddrQ       <= '0;
            wDataQ        <= '0;
            wStrbQ        <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SER_RESP_OKAY;
        end else begin
            awHeld        <= next_awHeld;
            wHeld         <= next_wHeld;
            awAddrQ       <= next_awAddrQ;
            wDataQ        <= next_wDataQ;
            wStrbQ        <= next_wStrbQ;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // The word is built from current flags; unused bits stay zero.
    always_comb begin
        rdSel     = decodeSel(s_axi_araddr);
        arTake    = s_axi_arvalid & s_axi_arready;
        faultRead = arTake && rdSel == SER_SEL_FAULT;
        rdWord    = '0;
        case (rdSel)
            SER_SEL_IDENTITY: begin
                rdWord[7:0] = PART_IDENTITY_CODE;
            end
            SER_SEL_FAULT: begin
                rdWord[`SER_FAULT_BOOT_BIT]  = faultFlags[0];
                rdWord[`SER_FAULT_CODE_MSB:`SER_FAULT_CODE_LSB] = faultCode;
                rdWord[`SER_FAULT_QUEUE_BIT] = faultFlags[1];
                rdWord[`SER_FAULT_AUXM_BIT]  = faultFlags[2];
            end
            SER_SEL_COND: begin
                rdWord[`SER_COND_MANUAL_BIT]    = manualBusy;
                rdWord[`SER_COND_CMD_IDLE_BIT]  = cmdIdle;
                rdWord[`SER_COND_AUX_FRESH_BIT] = freshFlags[0];
                rdWord[`SER_COND_ACC_FRESH_BIT] = freshFlags[1];
            end
            SER_SEL_IRQ_STAT: begin
                rdWord[`SER_IRQ_WIDTH-1:0] = irqStatus;
            end
            SER_SEL_IRQ_MASK: begin
                rdWord[`SER_IRQ_WIDTH-1:0] = irqMask;
            end
            default: begin
                rdWord = '0;
            end
        endcase
        next_rdState = rdState;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        case (rdState)
            SER_RD_IDLE: begin
                if (arTake) begin
                    next_rdState = SER_RD_RESP;
                    next_arready = 1'b0;
                    next_rvalid  = 1'b1;
                    next_rdata   = rdWord;
                    next_rresp   = (rdSel == SER_SEL_NONE) ? `SER_RESP_SLVERR
                                                           : `SER_RESP_OKAY;
                end
            end
            SER_RD_RESP: begin
                if (s_axi_rready) begin
                    next_rdState = SER_RD_IDLE;
                    next_arready = 1'b1;
                    next_rvalid  = 1'b0;
                end
            end
            default: begin
                next_rdState = SER_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdState       <= SER_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `SER_RESP_OKAY;
        end else begin
            rdState       <= next_rdState;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_boot_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        faultFlags[0] |=> faultFlags[0]) else $error("Boot fault flag dropped.");
    chk_code_value: assert property (@(posedge sys_clk) disable iff (rst)
        accelerometerConfigurationBad |=> faultCode == `SER_CODE_ACCELEROMETER_CONFIGURATION)
        else $error("Fault code not set for bad configuration.");
    chk_queue_clear: assert property (@(posedge sys_clk) disable iff (rst)
        faultRead && !queueDropped |=> !faultFlags[1])
        else $error("Queue overflow flag not cleared by read.");
    chk_auxm_set: assert property (@(posedge sys_clk) disable iff (rst)
        auxMasterFault |=> faultFlags[2]) else $error("Aux master fault lost.");
    chk_cmd_idle: assert property (@(posedge sys_clk) disable iff (rst)
        commandBusy ##1 !commandBusy |-> !cmdIdle ##1 cmdIdle)
        else $error("Command idle bit does not follow.");
    chk_acc_fresh: assert property (@(posedge sys_clk) disable iff (rst)
        accelDataRead && !accelNewSample |=> !freshFlags[1])
        else $error("Accel fresh flag not cleared.");
    chk_aux_fresh: assert property (@(posedge sys_clk) disable iff (rst)
        auxNewSample |=> freshFlags[0]) else $error("Aux fresh flag not set.");
    chk_manual_bit: assert property (@(posedge sys_clk) disable iff (rst)
        manualAuxiliaryTransfer |=> manualBusy) else $error("Manual transfer bit low.");
    chk_ident_read: assert property (@(posedge sys_clk) disable iff (rst)
        arTake && rdSel == SER_SEL_IDENTITY |=>
        s_axi_rvalid && s_axi_rdata == {24'h0, PART_IDENTITY_CODE})
        else $error("Identification read wrong.");
    chk_fault_reserved: assert property (@(posedge sys_clk) disable iff (rst)
        arTake && rdSel == SER_SEL_FAULT |=> s_axi_rdata[5] == 1'b0 &&
        s_axi_rdata[31:8] == 24'h0) else $error("Reserved fault bits set.");

endmodule

// ===== logic/ser_sticky.sv
// Bank of sticky flags in which a set always wins over a clear in the same cycle.
`timescale 1ns/1ps
module ser_sticky #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Per-bit set and clear pulses.
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic [WIDTH-1:0] clrBits,
    // Held flags.
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags; // Next value of the flags.

    // ****************************************************************
    // Next values
    // ****************************************************************
    // The set term is ORed last, so an event in the clearing cycle survives.
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_flags[i] = (flags[i] & ~clrBits[i]) | setBits[i];
            end
        end
    endgenerate

    // Flags start clear after reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule

// ===== logic/ser_sync2.sv
// Two-stage synchroniser for levels that arrive from another clock domain.
`timescale 1ns/1ps
module ser_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Asynchronous level in, synchronised level out.
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;      // First stage, read only by the second stage.
    logic [WIDTH-1:0] next_stage1; // Next value of the first stage.
    logic [WIDTH-1:0] next_sync;   // Next value of the second stage.

    // ****************************************************************
    // Next values
    // ****************************************************************
    // Each bit is handled alone; no bus coherence is promised across bits.
    always_comb begin
        next_stage1 = asyncIn;
        next_sync   = stage1;
    end

    // Both stages clear to zero so a fault cannot be seen during reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= next_stage1;
            syncOut <= next_sync;
        end
    end

endmodule

// ===== verification/ser_host.sv
// Host model that reaches the register bank over AXI4-Lite.
`timescale 1ns/1ps
module ser_host (
    // Clock.
    input  wire logic   sys_clk,
    // Requests to the bank.
    output logic [7:0]  s_axi_awaddr, s_axi_araddr,
    output logic [31:0] s_axi_wdata,
    output logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready,
    output logic        s_axi_arvalid, s_axi_rready,
    // Answers from the bank.
    input  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid,
    input  wire logic   s_axi_arready, s_axi_rvalid
);
    // Everything idle at time zero.
    initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
             s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    // Write; released payload is inverted so a stale value is never seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wdata <= ~d;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        s_axi_awaddr <= ~a;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    // Read; the bench monitor takes the data at the answer edge.
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_araddr  <= ~a;
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready  <= 1'b0;
    endtask
endmodule

// ===== verification/ser_regbank_tb.sv
// Self-checking bench for the status and error register bank.
`timescale 1ns/1ps
module ser_regbank_tb import ser_pkg::*;;
    localparam ser_byte_t ID = 8'h3c; // Arbitrary value.
    logic sys_clk = 1'b0, rst = 1'b1, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [5:0] evt = 6'h00; // Core event pulses.
    logic commandBusy = 1'b0, manualAuxiliaryTransfer = 1'b0;
    logic accelerometerConfigurationBad = 1'b0, bootFault = 1'b0;
    logic [33:0] q[$]; // Expected {resp, data} notes.
    integer mismatches = 0, comparisons = 0, cyc = 0, seed = 32'hb9211e59;
    always #5 sys_clk = ~sys_clk;
    ser_regbank #(.PART_IDENTITY_CODE(ID)) u_ser_regbank (.sys_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .queueDropped(evt[5]), .auxMasterFault(evt[4]),
        .accelNewSample(evt[3]), .auxNewSample(evt[2]), .accelDataRead(evt[1]),
        .auxDataRead(evt[0]), .commandBusy, .manualAuxiliaryTransfer,
        .accelerometerConfigurationBad, .bootFault, .irq);
    ser_host u_ser_host (.sys_clk, .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata,
        .s_axi_awvalid, .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rready,
        .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid);
    task automatic check(input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Each bus answer is paired with the oldest note; a hang is cut short.
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready) check(q.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) check(q.pop_front(), {s_axi_bresp, 32'h0});
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'b00);
        q.push_back({r, 24'h0, e});
        u_ser_host.rd(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
        q.push_back({r, 32'h0});
        u_ser_host.wr(a, d);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge sys_clk);
        evt <= m;
        @(posedge sys_clk);
        evt <= 6'h00;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h00, ID);
        rd(8'h08, 8'h00);
        rd(8'h0c, 8'h10);
        rd(8'h40, 8'h00, 2'b10);
        wr(8'h00, $random(seed));
        wr(8'h0c, $random(seed));
        rd(8'h00, ID);
        rd(8'h0c, 8'h10);
        $display("test 1 done");
        bootFault <= 1'b1;
        accelerometerConfigurationBad <= 1'b1;
        pulse(6'h30);
        repeat (4) @(posedge sys_clk);
        rd(8'h08, 8'hc3);
        rd(8'h08, 8'h03);
        accelerometerConfigurationBad <= 1'b0;
        rd(8'h08, 8'h01);
        $display("test 2 done");
        commandBusy <= 1'b1;
        manualAuxiliaryTransfer <= 1'b1;
        pulse(6'h0c);
        rd(8'h0c, 8'ha4);
        pulse(6'h02);
        rd(8'h0c, 8'h24);
        commandBusy <= 1'b0;
        manualAuxiliaryTransfer <= 1'b0;
        pulse(6'h01);
        rd(8'h0c, 8'h10);
        $display("test 3 done");
        check(34'h0, {33'h0, irq});
        wr(8'h14, 32'h8);
        rd(8'h14, 8'h08);
        check(34'h1, {33'h0, irq});
        wr(8'h10, 32'h8);
        rd(8'h10, 8'h17);
        check(34'h0, {33'h0, irq});
        $display("test 4 done");
        // A write whose low byte lane is off must leave the mask alone.
        s_axi_wstrb <= 4'he;
        wr(8'h14, 32'h1f);
        s_axi_wstrb <= 4'hf;
        rd(8'h14, 8'h08);
        // Unaligned addresses answer SLVERR and change nothing.
        wr(8'h41, $random(seed), 2'b10);
        rd(8'h0f, 8'h00, 2'b10);
        $display("test 5 done");
        // A reset in mid-run is the only thing that clears the boot fault flag.
        bootFault <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h08, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h0c, 8'h10);
        check(34'h0, {33'h0, irq});
        $display("test 6 done");
        finish_test();
    end
endmodule
